// File: verilog/twe_cfg.svh
`ifndef TWE_CFG_SVH
`define TWE_CFG_SVH
`define TWE_TYPE_ID 4'ha
`define TWE_PAGE_BYTES 8
`define TWE_PAGES_SMALL 16
`define TWE_PAGES_LARGE 32
`define TWE_WR_TIME_US 5000
`define TWE_MCLK_MHZ 250
`define TWE_WR_CYCLES (`TWE_WR_TIME_US * `TWE_MCLK_MHZ)
`define TWE_ERASED 8'hff
`endif

// File: verilog/twe_pkg.sv
package twe_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADDR, ST_WORDADDR, ST_DATA, ST_IGNORE
  } twe_phase_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic we;
  } twe_mem_wr_s;
endpackage

// File: verilog/twe_page_mem.sv
`timescale 1ns/1ps
module twe_page_mem #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire twe_pkg::twe_mem_wr_s wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk) begin
    if (wr.we) begin
      mem[wr.addr[$clog2(DEPTH)-1:0]] <= wr.data;
    end
    rd_data <= mem[rd_addr[$clog2(DEPTH)-1:0]];
  end
endmodule

// File: verilog/twe_eeprom.sv
`timescale 1ns/1ps
`include "twe_cfg.svh"
module twe_eeprom #(
  parameter bit LARGE = 1'b1,
  parameter bit HAS_STRAPS = 1'b1,
  parameter int unsigned WR_CYCLES = `TWE_WR_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_addr_bit0,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit2,
  output logic busy,
  output logic standby
);
  localparam int DEPTH = (LARGE ? `TWE_PAGES_LARGE : `TWE_PAGES_SMALL) * `TWE_PAGE_BYTES;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] st0_s;
    logic [2:0] st1_s;
    logic [2:0] st2_s;
    logic scl_v;
    logic sda_v;
    twe_pkg::twe_phase_e phase;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic ack_slot;
    logic ack_pend;
    logic drive_ack;
    logic [7:0] addr;
    logic [`TWE_PAGE_BYTES-1:0][7:0] pbuf;
    logic [`TWE_PAGE_BYTES-1:0] pval;
    logic got_data;
    logic prog;
    logic [2:0] pidx;
    logic [31:0] wcnt;
    logic stby;
  } twe_state_s;

  twe_state_s q_r, q_nxt;
  twe_pkg::twe_mem_wr_s mwr;
  logic [7:0] rd_unused;
  logic [2:0] strap_v;

  function automatic logic agree(input logic [2:0] s);
    return s[2] == s[1];
  endfunction

  // only the middle stage is used for the straps, with no agreement check; the first stage just settles
  always_comb begin
    strap_v = HAS_STRAPS ? {q_r.st2_s[1], q_r.st1_s[1], q_r.st0_s[1]} : 3'h0;
  end

  always_comb begin
    logic rise, fall, start_c, stop_c, match;
    logic [7:0] b;
    rise = 1'b0;
    fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    match = 1'b0;
    b = 8'h00;
    q_nxt = q_r;
    mwr = '0;
    q_nxt.scl_s = {q_r.scl_s[1:0], scl};
    q_nxt.sda_s = {q_r.sda_s[1:0], sda_in};
    q_nxt.st0_s = {q_r.st0_s[1:0], strap_addr_bit0};
    q_nxt.st1_s = {q_r.st1_s[1:0], strap_addr_bit1};
    q_nxt.st2_s = {q_r.st2_s[1:0], strap_addr_bit2};
    if (agree(q_r.scl_s)) begin
      q_nxt.scl_v = q_r.scl_s[2];
    end
    if (agree(q_r.sda_s)) begin
      q_nxt.sda_v = q_r.sda_s[2];
    end
    rise = !q_r.scl_v && q_nxt.scl_v;
    fall = q_r.scl_v && !q_nxt.scl_v;
    start_c = q_r.scl_v && q_nxt.scl_v && q_r.sda_v && !q_nxt.sda_v;
    stop_c = q_r.scl_v && q_nxt.scl_v && !q_r.sda_v && q_nxt.sda_v;
    b = {q_r.shift[6:0], q_nxt.sda_v};
    match = (b[7:4] == `TWE_TYPE_ID) && (b[3:1] == strap_v);
    if (q_r.prog) begin
      // inputs are dead while programming, one buffered byte per clock
      q_nxt.phase = twe_pkg::ST_IDLE;
      q_nxt.drive_ack = 1'b0;
      if (q_r.pval[q_r.pidx]) begin
        mwr.we = 1'b1;
        mwr.addr = {q_r.addr[7:3], q_r.pidx};
        mwr.data = q_r.pbuf[q_r.pidx];
      end
      q_nxt.pidx = q_r.pidx + 3'h1;
      if (q_r.wcnt >= WR_CYCLES - 1) begin
        q_nxt.prog = 1'b0;
        q_nxt.stby = 1'b1;
        q_nxt.pval = '0;
      end else begin
        q_nxt.wcnt = q_r.wcnt + 32'h1;
      end
    end else if (start_c) begin
      q_nxt.phase = twe_pkg::ST_DEVADDR;
      q_nxt.bitn = 4'h0;
      q_nxt.ack_slot = 1'b0;
      q_nxt.ack_pend = 1'b0;
      q_nxt.drive_ack = 1'b0;
      q_nxt.stby = 1'b0;
      q_nxt.got_data = 1'b0;
      q_nxt.pval = '0;
    end else if (stop_c) begin
      q_nxt.phase = twe_pkg::ST_IDLE;
      q_nxt.drive_ack = 1'b0;
      if (q_r.got_data) begin
        q_nxt.prog = 1'b1;
        q_nxt.wcnt = 32'h0;
        q_nxt.pidx = 3'h0;
      end else begin
        q_nxt.stby = 1'b1;
      end
      q_nxt.got_data = 1'b0;
    end else if (rise && q_r.phase != twe_pkg::ST_IDLE && q_r.phase != twe_pkg::ST_IGNORE) begin
      if (!q_r.ack_slot) begin
        q_nxt.shift = b;
        q_nxt.bitn = q_r.bitn + 4'h1;
        if (q_r.bitn == 4'h7) begin
          q_nxt.ack_slot = 1'b1;
          q_nxt.bitn = 4'h0;
          unique case (q_r.phase)
            twe_pkg::ST_DEVADDR: begin
              // reads are not served here, so a read address is not acked
              // ack waits for the falling edge: driving now would fake a start
              q_nxt.ack_pend = match && !b[0];
              q_nxt.phase = (match && !b[0]) ? twe_pkg::ST_WORDADDR : twe_pkg::ST_IGNORE;
            end
            twe_pkg::ST_WORDADDR: begin
              q_nxt.addr = LARGE ? b : {1'b0, b[6:0]};
              q_nxt.ack_pend = 1'b1;
              q_nxt.phase = twe_pkg::ST_DATA;
            end
            twe_pkg::ST_DATA: begin
              q_nxt.pbuf[q_r.addr[2:0]] = b;
              q_nxt.pval[q_r.addr[2:0]] = 1'b1;
              q_nxt.addr = {q_r.addr[7:3], q_r.addr[2:0] + 3'h1};
              q_nxt.got_data = 1'b1;
              q_nxt.ack_pend = 1'b1;
            end
            default: q_nxt.phase = twe_pkg::ST_IGNORE;
          endcase
        end
      end else begin
        q_nxt.ack_slot = 1'b0;
      end
    end else if (fall) begin
      q_nxt.drive_ack = q_r.ack_slot && q_r.ack_pend;
    end
    if (q_r.phase == twe_pkg::ST_IGNORE) begin
      q_nxt.drive_ack = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q_r <= '{scl_s: 3'h7, sda_s: 3'h7, scl_v: 1'b1, sda_v: 1'b1,
               phase: twe_pkg::ST_IDLE, stby: 1'b1, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  twe_page_mem #(.DEPTH(DEPTH)) u_mem (
    .clk(mclk),
    .wr(mwr),
    .rd_addr(q_r.addr),
    .rd_data(rd_unused)
  );

  assign sda_out = 1'b0;
  // ack is held from the falling edge before the ninth clock to the one after
  assign sda_oe = q_r.drive_ack;
  assign busy = q_r.prog;
  assign standby = q_r.stby;

  busy_quiet_a: assert property (@(posedge mclk) disable iff (reset) busy |-> !sda_oe)
    else $error("data line driven while programming");
  stop_prog_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(busy) |-> $past(q_r.got_data))
    else $error("programming without data");
  stby_end_a: assert property (@(posedge mclk) disable iff (reset)
    $fell(busy) |-> standby)
    else $error("no standby after write");
  page_keep_a: assert property (@(posedge mclk) disable iff (reset)
    q_r.phase == twe_pkg::ST_DATA && $past(q_r.phase) == twe_pkg::ST_DATA
    |-> q_r.addr[7:3] == $past(q_r.addr[7:3]))
    else $error("page bits changed");
  type_nack_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(q_r.ack_slot) && $past(q_r.phase) == twe_pkg::ST_DEVADDR && q_r.shift[7:4] != 4'ha
    |-> !q_r.ack_pend)
    else $error("acked wrong type");
  ack_window_a: assert property (@(posedge mclk) disable iff (reset)
    sda_oe |-> q_r.ack_slot || q_r.phase != twe_pkg::ST_IDLE)
    else $error("drive outside ack");
  strap_cmp_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(q_r.ack_slot) && $past(q_r.phase) == twe_pkg::ST_DEVADDR && q_r.ack_pend
    |-> q_r.shift[3:1] == strap_v)
    else $error("strap mismatch acked");
  rw_bit_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(q_r.ack_slot) && $past(q_r.phase) == twe_pkg::ST_DEVADDR && q_r.ack_pend
    |-> !q_r.shift[0])
    else $error("read acked");
endmodule

// File: verif/twe_host.sv
`timescale 1ns/1ps
module twe_host (
  input wire logic lclk,
  input wire logic sda,
  output logic scl,
  output logic pull_low
);
  // clock rests high between frames; data only ever pulled low, pull-up does the rest
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic tick(input logic c, input logic p);
    @(negedge lclk);
    scl = c;
    pull_low = p;
  endtask
  task automatic start();
    tick(1'b1, 1'b0);
    tick(1'b1, 1'b1);
    tick(1'b0, 1'b1);
  endtask
  task automatic stop();
    tick(1'b0, 1'b1);
    tick(1'b1, 1'b1);
    tick(1'b1, 1'b0);
  endtask
  // sample midway through the two-tick high phase so the device has settled its ack
  task automatic bit_cyc(input logic b, output logic s);
    tick(1'b0, ~b);
    tick(1'b1, ~b);
    tick(1'b1, ~b);
    s = sda;
    tick(1'b0, ~b);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic s);
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b[i], s);
    end
    bit_cyc(1'b1, s);
  endtask
endmodule

// File: verif/twe_eeprom_tb_top.sv
`timescale 1ns/1ps
module twe_eeprom_tb_top;
  localparam logic [7:0] DEV_W = 8'haa;
  logic mclk, reset, lclk, scl, pull_low, sda, sda_out, sda_oe, busy, standby, s;
  logic [2:0] strap;
  int failures, cmp_count, n;
  assign sda = ~(pull_low | (sda_oe & ~sda_out));
  twe_eeprom #(.LARGE(1'b1), .HAS_STRAPS(1'b1), .WR_CYCLES(2000)) u_twe_eeprom (
    .mclk(mclk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit2(strap[2]), .busy(busy), .standby(standby));
  twe_host u_twe_host (.lclk(lclk), .sda(sda), .scl(scl), .pull_low(pull_low));
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #6 lclk = ~lclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic addr(input logic [7:0] a);
    u_twe_host.start();
    u_twe_host.send_byte(a, s);
  endtask
  task automatic settle_wait();
    n = 0;
    while (busy === 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic test_addr();
    addr(8'hea);
    chk({7'h0, s}, 8'h01);
    u_twe_host.stop();
    addr(8'ha6);
    chk({7'h0, s}, 8'h01);
    u_twe_host.stop();
    addr(DEV_W);
    chk({7'h0, s}, 8'h00);
    u_twe_host.stop();
    repeat (6) @(negedge mclk);
    chk({6'h0, busy, standby}, 8'h01);
    $display("test addr done");
  endtask
  task automatic test_write(input int cnt);
    addr(DEV_W);
    chk({7'h0, s}, 8'h00);
    u_twe_host.send_byte(8'h18, s);
    chk({7'h0, s}, 8'h00);
    for (int i = 0; i < cnt; i++) begin
      u_twe_host.send_byte(8'h5a + i[7:0], s);
      chk({7'h0, s}, 8'h00);
    end
    u_twe_host.stop();
    repeat (6) @(negedge mclk);
    chk({6'h0, busy, standby}, 8'h02);
    addr(DEV_W);
    chk({7'h0, s}, 8'h01);
    u_twe_host.stop();
    settle_wait();
    @(negedge mclk);
    chk({6'h0, busy, standby}, 8'h01);
    addr(DEV_W);
    chk({7'h0, s}, 8'h00);
    u_twe_host.stop();
    $display("test write %0d done", cnt);
  endtask
  task automatic test_recover();
    u_twe_host.start();
    for (int i = 7; i >= 0; i--) begin
      u_twe_host.bit_cyc(DEV_W[i], s);
    end
    s = 1'b0;
    n = 0;
    while (s !== 1'b1 && n < 9) begin
      u_twe_host.bit_cyc(1'b1, s);
      n++;
    end
    chk({7'h0, s}, 8'h01);
    addr(DEV_W);
    chk({7'h0, s}, 8'h00);
    u_twe_host.stop();
    $display("test recover done");
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    strap = 3'b101;
    repeat (12) @(posedge mclk);
    @(negedge mclk) reset = 1'b0;
    repeat (4) @(posedge mclk);
    test_addr();
    test_write(1);
    test_write(8);
    test_recover();
    print_verdict();
  end
endmodule
